//--- hw/cycle_timing_pkg.sv
package cycle_timing_pkg;

  typedef enum logic [3:0] {
    M_DREG, M_AREG, M_IND, M_POSTINC, M_PREDEC, M_DISP, M_INDEX,
    M_ABS_W, M_ABS_L, M_PC_DISP, M_PC_INDEX, M_IMM
  } ea_mode_t;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} op_size_t;

  typedef enum logic [3:0] {
    OP_MOVE, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_CMP, OP_EXCLUSIVE_OR,
    OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_SIGNED, OP_DIVIDE_UNSIGNED,
    OP_DIVIDE_SIGNED, OP_IMMEDIATE, OP_SINGLE, OP_SHIFT
  } op_class_t;

  localparam int EA_MODES = 12;

  // operand locator cost, byte/word and long, indexed by ea_mode_t
  localparam logic [4:0] EA_CLK_BW [EA_MODES] = '{5'h00, 5'h00, 5'h04, 5'h04, 5'h06, 5'h08,
                                                 5'h0a, 5'h08, 5'h0c, 5'h08, 5'h0a, 5'h04};
  localparam logic [2:0] EA_RD_BW  [EA_MODES] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2,
                                                 3'h2, 3'h2, 3'h3, 3'h2, 3'h2, 3'h1};
  localparam logic [4:0] EA_CLK_L  [EA_MODES] = '{5'h00, 5'h00, 5'h08, 5'h08, 5'h0a, 5'h0c,
                                                 5'h0e, 5'h0c, 5'h10, 5'h0c, 5'h0e, 5'h08};
  localparam logic [2:0] EA_RD_L   [EA_MODES] = '{3'h0, 3'h0, 3'h2, 3'h2, 3'h2, 3'h3,
                                                 3'h3, 3'h3, 3'h4, 3'h3, 3'h3, 3'h2};

  localparam logic [9:0] PREDEC_DST_SAVE = 10'h002;
  localparam logic [9:0] MOVE_BASE_CLK   = 10'h004;
  localparam logic [9:0] REG_BW_CLK      = 10'h004;
  localparam logic [9:0] REG_L_CLK       = 10'h006;
  localparam logic [9:0] REG_L_RI_CLK    = 10'h008;
  localparam logic [9:0] TO_AREG_BW_CLK  = 10'h008;
  localparam logic [9:0] CMP_AREG_CLK    = 10'h006;
  localparam logic [9:0] MEM_BW_CLK      = 10'h008;
  localparam logic [9:0] MEM_L_CLK       = 10'h00c;
  localparam logic [9:0] XOR_L_CLK       = 10'h008;
  localparam logic [9:0] MUL_BASE_CLK    = 10'h026;
  localparam logic [9:0] DIVIDE_SIGNED_MAX_CLK    = 10'h09e;
  localparam logic [9:0] DIVIDE_UNSIGNED_MAX_CLK    = 10'h08c;
  localparam logic [9:0] IMM_REG_BW_CLK  = 10'h008;
  localparam logic [9:0] IMM_REG_L_CLK   = 10'h010;
  localparam logic [9:0] IMM_MEM_BW_CLK  = 10'h00c;
  localparam logic [9:0] IMM_MEM_L_CLK   = 10'h014;
  localparam logic [9:0] SHIFT_BW_CLK    = 10'h006;
  localparam logic [9:0] SHIFT_L_CLK     = 10'h008;

endpackage : cycle_timing_pkg

//--- hw/operand_locator_cost.sv
module operand_locator_cost
  import cycle_timing_pkg::*;
(
  // request
  input  wire ea_mode_t   mode,
  input  wire logic       is_long,
  // cost
  output logic [4:0]      clk_cost,
  output logic [2:0]      rd_cost
);

  // no write cycles are ever spent here
  assign clk_cost = is_long ? EA_CLK_L[int'(mode)] : EA_CLK_BW[int'(mode)]; // R3
  assign rd_cost  = is_long ? EA_RD_L[int'(mode)]  : EA_RD_BW[int'(mode)]; // R3

endmodule : operand_locator_cost

//--- hw/instruction_cycle_timing.sv
// Functional notes
// R1 - figures assume four-clock bus cycles with no wait states
// R2 - every wait state adds one clock to the instruction total
// R3 - operand locator costs clocks and reads only; indirect 4(1/0) or 8(2/0)
// R4 - byte/word move abs-long to abs-long 28(6/1); indirect to indirect 12(2/1)
// R5 - long move data reg to indirect 12(1/2); abs-long to data reg 20(5/0)
// R6 - two-operand count covers operation, result store and next fetch
// R7 - where marked, locator clocks and reads add to base, summed separately
// R8 - long add/sub/and/or into register: six becomes eight for register/immediate source
// R9 - exclusive-or into data reg needs data reg source; 4(1/0) or 8(1/0)
// R10 - multiply takes 38 plus 2n clocks, at most 70, one read, plus locator
// R11 - unsigned multiply n is the count of ones in the source
// R12 - signed multiply n counts differing adjacent pairs of source with zero appended
// R13 - divide at most 158 signed, 140 unsigned, one read plus locator
// R14 - immediate ops include extension fetch, operation, write and next fetch
// R15 - single-operand memory ops add locator clocks and reads
// R16 - register shift by n: 6+2n byte/word, 8+2n long, one read
// R17 - maximum-only durations are never exceeded
module instruction_cycle_timing
  import cycle_timing_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // instruction request
  input  wire logic       start,
  input  wire op_class_t  op_class,
  input  wire op_size_t   op_size,
  input  wire ea_mode_t   src_mode,
  input  wire ea_mode_t   dst_mode,
  input  wire logic [15:0] mul_operand,
  input  wire logic [5:0] shift_count,
  input  wire logic [7:0] wait_states,
  // status
  output logic            busy,
  output logic            done,
  output logic            illegal,
  output logic [9:0]      clocks_q,
  output logic [3:0]      reads_q,
  output logic [1:0]      writes_q
);

  logic [9:0] remaining_q;
  logic [9:0] remaining_d;
  logic       done_q;
  logic [4:0] src_clk;
  logic [2:0] src_rd;
  logic [4:0] dst_clk;
  logic [2:0] dst_rd;
  logic [9:0] base_clk;
  logic [3:0] base_rd;
  logic [1:0] base_wr;
  logic       add_ea;
  logic       bad_combo;
  logic [4:0] mul_n;
  logic [15:0] pair_diff;

  wire is_long    = (op_size == SZ_LONG);
  wire dst_reg    = (dst_mode == M_DREG) || (dst_mode == M_AREG);
  wire dst_mem    = !dst_reg;
  wire src_dreg   = (src_mode == M_DREG);
  wire src_reg_im = (src_mode == M_DREG) || (src_mode == M_AREG) || (src_mode == M_IMM);
  wire dst_bad    = (dst_mode == M_PC_DISP) || (dst_mode == M_PC_INDEX) || (dst_mode == M_IMM);
  wire accept     = start && !busy && !bad_combo;

  operand_locator_cost u_src_cost (
    .mode     (src_mode),
    .is_long  (is_long),
    .clk_cost (src_clk),
    .rd_cost  (src_rd)
  );

  operand_locator_cost u_dst_cost (
    .mode     (dst_mode),
    .is_long  (is_long),
    .clk_cost (dst_clk),
    .rd_cost  (dst_rd)
  );

  // locator for standard ops: source when result goes to a register, else destination
  wire [9:0] ea_clk = dst_mem ? {5'h00, dst_clk} : {5'h00, src_clk}; // R7
  wire [3:0] ea_rd  = dst_mem ? {1'b0, dst_rd}   : {1'b0, src_rd}; // R7

  // move destination: final operand read becomes write; predecrement costs no extra
  wire [3:0] dst_units = is_long ? 4'h2 : 4'h1;
  wire [9:0] mv_dst_clk = (dst_mode == M_PREDEC) ? {5'h00, dst_clk} - PREDEC_DST_SAVE
                                                 : {5'h00, dst_clk};
  wire [3:0] mv_dst_rd  = dst_mem ? {1'b0, dst_rd} - dst_units : 4'h0;
  wire [1:0] mv_dst_wr  = dst_mem ? dst_units[1:0] : 2'h0;

  // multiply bit-pattern counts
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_pair
      if (gi == 0) begin : g_lsb
        assign pair_diff[gi] = mul_operand[0]; // R12
      end else begin : g_up
        assign pair_diff[gi] = mul_operand[gi] ^ mul_operand[gi-1]; // R12
      end
    end
  endgenerate

  always_comb begin
    mul_n = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (op_class == OP_MULTIPLY_SIGNED) begin
        mul_n = mul_n + {4'h0, pair_diff[i]}; // R12
      end else begin
        mul_n = mul_n + {4'h0, mul_operand[i]}; // R11
      end
    end
  end

  wire [9:0] mul_clk   = MUL_BASE_CLK + {4'h0, mul_n, 1'b0}; // R10
  wire [9:0] shift_2n  = {3'h0, shift_count, 1'b0};
  wire [9:0] long_reg  = src_reg_im ? REG_L_RI_CLK : REG_L_CLK; // R8

  always_comb begin
    base_clk  = 10'h000;
    base_rd   = 4'h1;
    base_wr   = 2'h0;
    add_ea    = 1'b1;
    bad_combo = 1'b0;
    case (op_class)
      OP_MOVE: begin
        base_clk  = MOVE_BASE_CLK + {5'h00, src_clk} + mv_dst_clk; // R4 R5
        base_rd   = 4'h1 + {1'b0, src_rd} + mv_dst_rd; // R4 R5
        base_wr   = mv_dst_wr; // R5
        add_ea    = 1'b0;
        bad_combo = dst_bad;
      end
      OP_ADD, OP_SUB, OP_AND, OP_OR, OP_CMP: begin
        if (dst_mode == M_AREG) begin
          bad_combo = (op_class == OP_AND) || (op_class == OP_OR) || (op_size == SZ_BYTE);
          if (op_class == OP_CMP) begin
            base_clk = CMP_AREG_CLK;
          end else begin
            base_clk = is_long ? long_reg : TO_AREG_BW_CLK; // R8
          end
        end else if (dst_mode == M_DREG) begin
          if (!is_long) begin
            base_clk = REG_BW_CLK; // R6
          end else begin
            base_clk = (op_class == OP_CMP) ? REG_L_CLK : long_reg; // R8
          end
        end else begin
          bad_combo = !src_dreg || (op_class == OP_CMP) || dst_bad;
          base_clk  = is_long ? MEM_L_CLK : MEM_BW_CLK; // R6
          base_wr   = is_long ? 2'h2 : 2'h1; // R6
        end
      end
      OP_EXCLUSIVE_OR: begin
        bad_combo = !src_dreg || (dst_mode == M_AREG) || dst_bad; // R9
        if (dst_mode == M_DREG) begin
          base_clk = is_long ? XOR_L_CLK : REG_BW_CLK; // R9
          add_ea   = 1'b0; // R9
        end else begin
          base_clk = is_long ? MEM_L_CLK : MEM_BW_CLK;
          base_wr  = is_long ? 2'h2 : 2'h1;
        end
      end
      OP_MULTIPLY_UNSIGNED, OP_MULTIPLY_SIGNED: begin
        bad_combo = (dst_mode != M_DREG) || (src_mode == M_AREG);
        base_clk  = mul_clk; // R10
      end
      OP_DIVIDE_UNSIGNED, OP_DIVIDE_SIGNED: begin
        bad_combo = (dst_mode != M_DREG) || (src_mode == M_AREG);
        // worst case used; never beyond the ceiling
        base_clk  = (op_class == OP_DIVIDE_SIGNED) ? DIVIDE_SIGNED_MAX_CLK : DIVIDE_UNSIGNED_MAX_CLK; // R13 R17
      end
      OP_IMMEDIATE: begin
        bad_combo = (dst_mode == M_AREG) || dst_bad;
        if (dst_mode == M_DREG) begin
          base_clk = is_long ? IMM_REG_L_CLK : IMM_REG_BW_CLK; // R14
          base_rd  = is_long ? 4'h3 : 4'h2; // R14
          add_ea   = 1'b0; // R14
        end else begin
          base_clk = is_long ? IMM_MEM_L_CLK : IMM_MEM_BW_CLK; // R14
          base_rd  = is_long ? 4'h3 : 4'h2; // R14
          base_wr  = is_long ? 2'h2 : 2'h1; // R14
        end
      end
      OP_SINGLE: begin
        bad_combo = (dst_mode == M_AREG) || dst_bad;
        if (dst_mode == M_DREG) begin
          base_clk = is_long ? REG_L_CLK : REG_BW_CLK;
          add_ea   = 1'b0; // R15
        end else begin
          base_clk = is_long ? MEM_L_CLK : MEM_BW_CLK; // R15
          base_wr  = is_long ? 2'h2 : 2'h1; // R15
        end
      end
      OP_SHIFT: begin
        if (dst_mode == M_DREG) begin
          base_clk = (is_long ? SHIFT_L_CLK : SHIFT_BW_CLK) + shift_2n; // R16
          add_ea   = 1'b0; // R16
        end else begin
          // memory shifts are word size by one position only
          bad_combo = (op_size != SZ_WORD) || (dst_mode == M_AREG) || dst_bad;
          base_clk  = MEM_BW_CLK;
          base_wr   = 2'h1;
        end
      end
      default: begin
        bad_combo = 1'b1;
      end
    endcase
  end

  // register-direct locators cost nothing, so register forms come out right
  wire [9:0] total_clk = base_clk + (add_ea ? ea_clk : 10'h000) + {2'h0, wait_states}; // R1 R2 R7
  wire [3:0] total_rd  = base_rd + (add_ea ? ea_rd : 4'h0); // R7

  assign remaining_d = accept ? total_clk :
                       (remaining_q != 10'h000) ? remaining_q - 10'h001 : 10'h000;
  assign busy        = (remaining_q != 10'h000);
  assign done        = done_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      remaining_q <= 10'h000;
      done_q      <= 1'b0;
      illegal     <= 1'b0;
      clocks_q    <= 10'h000;
      reads_q     <= 4'h0;
      writes_q    <= 2'h0;
    end else begin
      remaining_q <= remaining_d; // R2
      done_q      <= (remaining_q == 10'h001);
      if (start && !busy) begin
        illegal <= bad_combo;
      end
      if (accept) begin
        clocks_q <= total_clk;
        reads_q  <= total_rd;
        writes_q <= base_wr;
      end
    end
  end

  // helper: cycles busy since acceptance
  logic [9:0] elapsed_q;
  always_ff @(posedge clk) begin
    if (!reset_n || accept) begin
      elapsed_q <= 10'h000;
    end else if (busy) begin
      elapsed_q <= elapsed_q + 10'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  wire plain_req = accept && (wait_states == 8'h00);

  chk_done_after_count: assert property (done |-> elapsed_q == clocks_q) // R2
    else $error("done not after the counted clocks");
  chk_move_abs_long: assert property (plain_req && op_class == OP_MOVE && !is_long && // R4
      src_mode == M_ABS_L && dst_mode == M_ABS_L |=> clocks_q == 10'd28 && reads_q == 4'd6
      && writes_q == 2'd1)
    else $error("abs long move cost wrong");
  chk_move_indirect: assert property (plain_req && op_class == OP_MOVE && !is_long && // R4
      src_mode == M_IND && dst_mode == M_IND |=> clocks_q == 10'd12 && reads_q == 4'd2 && writes_q == 2'd1)
    else $error("indirect move cost wrong");
  chk_move_long_dst: assert property (plain_req && op_class == OP_MOVE && is_long && // R5
      src_mode == M_DREG && dst_mode == M_IND |=> clocks_q == 10'd12 && reads_q == 4'd1 && writes_q == 2'd2)
    else $error("long move to memory cost wrong");
  chk_move_long_src: assert property (plain_req && op_class == OP_MOVE && is_long && // R5
      src_mode == M_ABS_L && dst_mode == M_DREG |=> clocks_q == 10'd20 && reads_q == 4'd5
      && writes_q == 2'd0)
    else $error("long move from abs long cost wrong");
  chk_long_reg_src: assert property (plain_req && op_class == OP_ADD && is_long && // R8
      src_mode == M_DREG && dst_mode == M_DREG |=> clocks_q == 10'd8)
    else $error("long add register source not eight");
  chk_xor_data_reg: assert property (plain_req && op_class == OP_EXCLUSIVE_OR && // R9
      dst_mode == M_DREG |=> clocks_q == ($past(is_long) ? 10'd8 : 10'd4) && reads_q == 4'd1)
    else $error("exclusive or register cost wrong");
  chk_mul_worst: assert property (plain_req && src_mode == M_DREG && ((op_class == // R10 R11 R12
      OP_MULTIPLY_UNSIGNED && mul_operand == 16'hffff) || (op_class == OP_MULTIPLY_SIGNED
      && mul_operand == 16'h5555)) |=> clocks_q == 10'd70)
    else $error("multiply worst case not seventy");
  chk_mul_zero: assert property (plain_req && src_mode == M_DREG && mul_operand == 16'h0000 // R10
      && (op_class == OP_MULTIPLY_UNSIGNED || op_class == OP_MULTIPLY_SIGNED)
      |=> clocks_q == 10'd38)
    else $error("multiply minimum not 38");
  chk_div_ceiling: assert property (plain_req && src_mode == M_DREG && // R13 R17
      op_class == OP_DIVIDE_SIGNED |=> clocks_q <= 10'd158 && reads_q == 4'd1)
    else $error("signed divide over ceiling");
  chk_shift_reg: assert property (plain_req && op_class == OP_SHIFT && dst_mode == M_DREG // R16
      |=> clocks_q == ($past(is_long) ? SHIFT_L_CLK : SHIFT_BW_CLK) + {3'h0, $past(shift_count), 1'b0}
      && reads_q == 4'd1 && writes_q == 2'd0)
    else $error("register shift cost wrong");
  chk_imm_reg: assert property (plain_req && op_class == OP_IMMEDIATE && dst_mode == M_DREG // R14
      |=> clocks_q == ($past(is_long) ? 10'd16 : 10'd8) && reads_q == ($past(is_long) ? 4'd3 : 4'd2))
    else $error("immediate register cost wrong");
  chk_wait_adds: assert property (accept && op_class == OP_MOVE && !is_long && src_mode == M_DREG && // R1 R2
      dst_mode == M_DREG |=> clocks_q == 10'd4 + {2'h0, $past(wait_states)})
    else $error("wait states not added");

  cov_move: cover property (accept && op_class == OP_MOVE ##1 busy [*3] ##[1:40] done);
  cov_mul: cover property (accept && op_class == OP_MULTIPLY_SIGNED ##[1:80] done);
  cov_wait: cover property (accept && wait_states != 8'h00 ##[1:400] done);
  cov_illegal: cover property (start && !busy && bad_combo);

endmodule : instruction_cycle_timing

//--- bench/bus_wait_model.sv
module bus_wait_model (
  // stall control
  input  wire logic       slow,
  input  wire logic [3:0] bus_cycles,
  input  wire logic [3:0] wait_per_cycle,
  // stretch handed to the timer
  output logic      [7:0] wait_states
);
  timeunit 1ns;
  timeprecision 1ps;
  // prompt memory finishes each bus cycle in four clocks, slow memory stretches every one
  assign wait_states = slow ? 8'(bus_cycles * wait_per_cycle) : 8'h00;
endmodule : bus_wait_model

//--- bench/instruction_cycle_timing_tb.sv
module instruction_cycle_timing_tb
  import cycle_timing_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        reset_n;
  logic        start;
  op_class_t   op_class;
  op_size_t    op_size;
  ea_mode_t    src_mode;
  ea_mode_t    dst_mode;
  logic [15:0] mul_operand;
  logic [5:0]  shift_count;
  logic [7:0]  wait_states;
  logic        slow;
  logic [3:0]  bus_cycles;
  logic [3:0]  wait_per_cycle;
  logic        busy;
  logic        done;
  logic        illegal;
  logic [9:0]  clocks_q;
  logic [3:0]  reads_q;
  logic [1:0]  writes_q;
  int          n_errors;
  int          samples_checked;

  instruction_cycle_timing i_instruction_cycle_timing (
    .clk(clk), .reset_n(reset_n), .start(start), .op_class(op_class), .op_size(op_size),
    .src_mode(src_mode), .dst_mode(dst_mode), .mul_operand(mul_operand),
    .shift_count(shift_count), .wait_states(wait_states), .busy(busy), .done(done),
    .illegal(illegal), .clocks_q(clocks_q), .reads_q(reads_q), .writes_q(writes_q)
  );

  bus_wait_model i_bus_wait_model (
    .slow(slow), .bus_cycles(bus_cycles), .wait_per_cycle(wait_per_cycle), .wait_states(wait_states)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test();
    $display("errors %0d of %0d checks", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic cmp_cnt(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_cnt

  task automatic cmp_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_flag

  // one timed instruction; returns in the done cycle so the next may follow back to back
  task automatic run(input op_class_t c, input op_size_t s, input ea_mode_t sm, input ea_mode_t dm,
                     input logic [15:0] mo, input logic [5:0] sc, input logic [9:0] ec,
                     input logic [9:0] er, input logic [9:0] ew, input bit poke);
    logic [9:0] n;
    n = 10'h000;
    op_class = c;
    op_size = s;
    src_mode = sm;
    dst_mode = dm;
    mul_operand = mo;
    shift_count = sc;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    cmp_cnt(clocks_q, ec);
    cmp_cnt({6'h00, reads_q}, er);
    cmp_cnt({8'h00, writes_q}, ew);
    cmp_flag(illegal, 1'b0);
    while (busy === 1'b1 && n < 10'h3ff) begin
      @(posedge clk);
      #1;
      n++;
      if (poke && n == 10'h002) begin
        start = 1'b1;
        op_class = OP_SHIFT;
      end else if (poke && n == 10'h003) begin
        start = 1'b0;
      end
    end
    cmp_cnt(n, ec);
    cmp_flag(done, 1'b1);
    cmp_cnt(clocks_q, ec);
  endtask : run

  task automatic refuse(input op_class_t c, input op_size_t s, input ea_mode_t sm, input ea_mode_t dm);
    op_class = c;
    op_size = s;
    src_mode = sm;
    dst_mode = dm;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    cmp_flag(illegal, 1'b1);
    cmp_flag(busy, 1'b0);
    @(posedge clk);
    #1;
  endtask : refuse

  task automatic t_move();
    run(OP_MOVE, SZ_WORD, M_DREG,  M_DREG,  16'h0000, 6'h00, 10'h004, 10'h1, 10'h0, 0);
    run(OP_MOVE, SZ_WORD, M_ABS_L, M_ABS_L, 16'h0000, 6'h00, 10'h01c, 10'h6, 10'h1, 0);
    run(OP_MOVE, SZ_BYTE, M_IND,   M_IND,   16'h0000, 6'h00, 10'h00c, 10'h2, 10'h1, 0);
    run(OP_MOVE, SZ_LONG, M_DREG,  M_IND,   16'h0000, 6'h00, 10'h00c, 10'h1, 10'h2, 0);
    run(OP_MOVE, SZ_LONG, M_ABS_L, M_DREG,  16'h0000, 6'h00, 10'h014, 10'h5, 10'h0, 0);
    run(OP_MOVE, SZ_LONG, M_IND,   M_DREG,  16'h0000, 6'h00, 10'h00c, 10'h3, 10'h0, 0);
    run(OP_MOVE, SZ_WORD, M_DREG,  M_PREDEC, 16'h0000, 6'h00, 10'h008, 10'h1, 10'h1, 0);
  endtask : t_move

  task automatic t_standard();
    run(OP_ADD, SZ_WORD, M_DREG, M_IND,  16'h0000, 6'h00, 10'h00c, 10'h2, 10'h1, 0);
    run(OP_ADD, SZ_LONG, M_DREG, M_DREG, 16'h0000, 6'h00, 10'h008, 10'h1, 10'h0, 0);
    run(OP_SUB, SZ_LONG, M_IMM,  M_DREG, 16'h0000, 6'h00, 10'h010, 10'h3, 10'h0, 0);
    run(OP_OR,  SZ_LONG, M_IND,  M_DREG, 16'h0000, 6'h00, 10'h00e, 10'h3, 10'h0, 0);
    run(OP_EXCLUSIVE_OR, SZ_WORD, M_DREG, M_DREG, 16'h0000, 6'h00, 10'h004, 10'h1, 10'h0, 0);
    run(OP_EXCLUSIVE_OR, SZ_LONG, M_DREG, M_DREG, 16'h0000, 6'h00, 10'h008, 10'h1, 10'h0, 0);
    refuse(OP_EXCLUSIVE_OR, SZ_WORD, M_IND, M_DREG);
    refuse(OP_AND, SZ_WORD, M_DREG, M_AREG);
  endtask : t_standard

  task automatic t_multiply();
    run(OP_MULTIPLY_UNSIGNED, SZ_WORD, M_DREG, M_DREG, 16'hffff, 6'h00, 10'h046, 10'h1, 10'h0, 0);
    run(OP_MULTIPLY_UNSIGNED, SZ_WORD, M_DREG, M_DREG, 16'h0003, 6'h00, 10'h02a, 10'h1, 10'h0, 0);
    run(OP_MULTIPLY_UNSIGNED, SZ_WORD, M_DREG, M_DREG, 16'h0000, 6'h00, 10'h026, 10'h1, 10'h0, 0);
    run(OP_MULTIPLY_SIGNED,   SZ_WORD, M_DREG, M_DREG, 16'h5555, 6'h00, 10'h046, 10'h1, 10'h0, 0);
    run(OP_MULTIPLY_SIGNED,   SZ_WORD, M_DREG, M_DREG, 16'hffff, 6'h00, 10'h028, 10'h1, 10'h0, 0);
    run(OP_MULTIPLY_SIGNED,   SZ_WORD, M_IND,  M_DREG, 16'h0000, 6'h00, 10'h02a, 10'h2, 10'h0, 0);
  endtask : t_multiply

  task automatic t_divide();
    run(OP_DIVIDE_SIGNED,   SZ_WORD, M_DREG, M_DREG, 16'h0000, 6'h00, 10'h09e, 10'h1, 10'h0, 0);
    run(OP_DIVIDE_UNSIGNED, SZ_WORD, M_IND,  M_DREG, 16'h0000, 6'h00, 10'h090, 10'h2, 10'h0, 0);
  endtask : t_divide

  task automatic t_other();
    run(OP_IMMEDIATE, SZ_WORD, M_IMM, M_DREG, 16'h0000, 6'h00, 10'h008, 10'h2, 10'h0, 0);
    run(OP_IMMEDIATE, SZ_LONG, M_IMM, M_IND,  16'h0000, 6'h00, 10'h01c, 10'h5, 10'h2, 0);
    run(OP_SINGLE,    SZ_LONG, M_DREG, M_DREG, 16'h0000, 6'h00, 10'h006, 10'h1, 10'h0, 0);
    run(OP_SINGLE,    SZ_WORD, M_DREG, M_IND,  16'h0000, 6'h00, 10'h00c, 10'h2, 10'h1, 0);
    run(OP_SHIFT, SZ_WORD, M_DREG, M_DREG, 16'h0000, 6'h03, 10'h00c, 10'h1, 10'h0, 0);
    run(OP_SHIFT, SZ_LONG, M_DREG, M_DREG, 16'h0000, 6'h00, 10'h008, 10'h1, 10'h0, 0);
    run(OP_SHIFT, SZ_LONG, M_DREG, M_DREG, 16'h0000, 6'h3f, 10'h086, 10'h1, 10'h0, 0);
    run(OP_SHIFT, SZ_WORD, M_IND,  M_DREG, 16'h0000, 6'h01, 10'h008, 10'h1, 10'h0, 0);
  endtask : t_other

  // slow memory stretches the total, then a start while busy must leave the count alone
  task automatic t_waits();
    slow = 1'b1;
    bus_cycles = 4'h1;
    wait_per_cycle = 4'h3;
    run(OP_MOVE, SZ_WORD, M_DREG, M_DREG, 16'h0000, 6'h00, 10'h007, 10'h1, 10'h0, 0);
    bus_cycles = 4'h7;
    wait_per_cycle = 4'h2;
    run(OP_MOVE, SZ_WORD, M_ABS_L, M_ABS_L, 16'h0000, 6'h00, 10'h02a, 10'h6, 10'h1, 1);
    slow = 1'b0;
    run(OP_MOVE, SZ_WORD, M_DREG, M_DREG, 16'h0000, 6'h00, 10'h004, 10'h1, 10'h0, 0);
  endtask : t_waits

  initial begin
    n_errors = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    start = 1'b0;
    op_class = OP_MOVE;
    op_size = SZ_WORD;
    src_mode = M_DREG;
    dst_mode = M_DREG;
    mul_operand = 16'h0000;
    shift_count = 6'h00;
    slow = 1'b0;
    bus_cycles = 4'h0;
    wait_per_cycle = 4'h0;
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_move();
    t_standard();
    t_multiply();
    t_divide();
    t_other();
    t_waits();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule : instruction_cycle_timing_tb
